// File: rtl/plc_link_ctrl.sv
// Link negotiation, fault signalling, heartbeat, loopback and reset control
`timescale 1ns/1ps
module plc_link_ctrl
	import plc_pkg::*;
#(
	parameter int CW_WIDTH = 16
)
(
	input wire logic MCLK_IN,
	input wire logic RST_B_IN,
	input wire logic STRAP_AUTONEG_ENABLE_IN,
	input wire logic [2:0] TECH_SELECT_STRAPS_IN,
	input wire logic FIBER_MODE_IN,
	input wire logic CTL_WR_IN,
	input wire logic [15:0] CTL_WDATA_IN,
	input wire logic ADV_WR_IN,
	input wire logic [CW_WIDTH-1:0] ADV_WDATA_IN,
	input wire logic X21_WR_IN,
	input wire logic [15:0] X21_WDATA_IN,
	input wire logic X16_WR_IN,
	input wire logic [15:0] X16_WDATA_IN,
	input wire logic FEF_ENABLE_WR_IN,
	input wire logic FEF_ENABLE_IN,
	input wire logic CW_VALID_IN,
	input wire logic [CW_WIDTH-1:0] CW_IN,
	input wire logic NLP_DETECT_IN,
	input wire logic IDLE100_DETECT_IN,
	input wire logic LINK_LOSS_IN,
	input wire logic PARTNER_ACTIVE_IN,
	input wire logic LOCK_ERROR_IN,
	input wire logic TX_EN_IN,
	output logic [15:0] CTL_OUT,
	output logic [CW_WIDTH-1:0] ADV_OUT,
	output logic [CW_WIDTH-1:0] PARTNER_OUT,
	output logic [15:0] X21_OUT,
	output logic [15:0] X16_OUT,
	output logic FLP_SEND_OUT,
	output logic [CW_WIDTH-1:0] FLP_WORD_OUT,
	output logic SPEED_100_OUT,
	output logic FULL_DUPLEX_OUT,
	output logic LINK_UP_OUT,
	output logic FEF_ACTIVE_OUT,
	output logic FEF_BIT_OUT,
	output logic COL_OUT,
	output logic LOCAL_LOOP_OUT,
	output logic REMOTE_LOOP_OUT,
	output logic SIGNAL_DETECT_OUT,
	output logic TX_DRIVER_EN_OUT,
	output logic FORCE_LINK10_OUT,
	output logic SOFT_RESET_OUT
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic plc_result_t pick_mode(input logic [3:0] abil);
		plc_result_t r;
		r = '{speed_100: 1'b0, full_duplex: 1'b0, link_up: 1'b1};
		if (abil[3])
		begin
			r.speed_100 = 1'b1;
			r.full_duplex = 1'b1;
		end
		else if (abil[2])
			r.speed_100 = 1'b1;
		else if (abil[1])
			r.full_duplex = 1'b1;
		else if (!abil[0])
			r.link_up = 1'b0;
		return r;
	endfunction : pick_mode

	function automatic logic [3:0] tech_abil(input logic [2:0] t);
		logic [3:0] a;
		a = 4'h0;
		a[0] = t[0];
		a[2] = t[1];
		a[1] = t[2] & t[0];
		a[3] = t[2] & t[1];
		return a;
	endfunction : tech_abil

	// ------------------------------------------------------------
	// Reset sources and strap capture
	// ------------------------------------------------------------
	logic [4:0] swrst_cnt_reg;
	logic swrst_reg;
	logic straps_taken_reg;
	logic strap_aneg_reg;
	logic [2:0] strap_tech_reg;
	logic soft_clr;
	assign soft_clr = swrst_reg && (swrst_cnt_reg == 5'(SWRST_CYCLES - 1));

	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			swrst_reg <= 1'b0;
			swrst_cnt_reg <= 5'h00;
		end
		else if (CTL_WR_IN && CTL_WDATA_IN[CTL_RESET_BIT] && !swrst_reg)
		begin
			swrst_reg <= 1'b1;
			swrst_cnt_reg <= 5'h00;
		end
		else if (swrst_reg)
		begin
			swrst_cnt_reg <= swrst_cnt_reg + 5'h01;
			if (soft_clr)
				swrst_reg <= 1'b0;
		end
	end

	// Straps are caught on the first clock after release, never under reset
	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			straps_taken_reg <= 1'b0;
			strap_aneg_reg <= 1'b0;
			strap_tech_reg <= 3'h0;
		end
		else if (!straps_taken_reg)
		begin
			straps_taken_reg <= 1'b1;
			strap_aneg_reg <= STRAP_AUTONEG_ENABLE_IN;
			strap_tech_reg <= TECH_SELECT_STRAPS_IN;
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [15:0] ctl_reg;
	logic [CW_WIDTH-1:0] adv_reg;
	logic [3:0] adv_cap_reg;
	logic [15:0] x21_reg;
	logic [15:0] x16_reg;
	logic fef_en_reg;
	logic restart_pulse;
	logic init_reg;
	assign restart_pulse = CTL_WR_IN && CTL_WDATA_IN[CTL_RESTART_BIT];

	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			ctl_reg <= CTL_RESET_VAL;
			adv_reg <= '0;
			adv_cap_reg <= 4'h0;
			x21_reg <= 16'h0000;
			x16_reg <= 16'h0000;
			fef_en_reg <= 1'b0;
		end
		else if (swrst_reg || !straps_taken_reg)
		begin
			ctl_reg <= CTL_RESET_VAL;
			ctl_reg[CTL_ANEG_BIT] <= straps_taken_reg ? strap_aneg_reg : STRAP_AUTONEG_ENABLE_IN;
			ctl_reg[CTL_RESET_BIT] <= soft_clr ? 1'b0 : swrst_reg;
			adv_reg <= '0;
			adv_cap_reg <= tech_abil(straps_taken_reg ? strap_tech_reg : TECH_SELECT_STRAPS_IN);
			adv_reg[ADV_TECH_MSB:ADV_TECH_LSB] <= tech_abil(straps_taken_reg ? strap_tech_reg
				: TECH_SELECT_STRAPS_IN);
			x21_reg <= 16'h0000;
			x16_reg <= 16'h0000;
			fef_en_reg <= FIBER_MODE_IN;
		end
		else
		begin
			if (CTL_WR_IN)
				ctl_reg <= CTL_WDATA_IN;
			if (ADV_WR_IN)
			begin
				adv_reg <= ADV_WDATA_IN;
				adv_reg[ADV_TECH_MSB:ADV_TECH_LSB] <= ADV_WDATA_IN[ADV_TECH_MSB:ADV_TECH_LSB] & adv_cap_reg;
			end
			if (X21_WR_IN)
				x21_reg <= X21_WDATA_IN;
			if (X16_WR_IN)
				x16_reg <= X16_WDATA_IN;
			if (FEF_ENABLE_WR_IN)
				fef_en_reg <= FEF_ENABLE_IN;
		end
	end

	// ------------------------------------------------------------
	// Negotiation
	// ------------------------------------------------------------
	plc_state_t state_reg;
	logic [CW_WIDTH-1:0] last_cw_reg;
	logic [1:0] match_cnt_reg;
	logic [CW_WIDTH-1:0] partner_reg;
	logic [CW_WIDTH-1:0] flp_word_reg;
	plc_result_t res_reg;
	logic aneg_on;
	logic cw_same;
	logic [CW_WIDTH-1:0] ack_mask;
	assign aneg_on = ctl_reg[CTL_ANEG_BIT];
	assign ack_mask = ~(CW_WIDTH'(1) << ADV_ACK_BIT);
	assign cw_same = ((CW_IN & ack_mask) == (last_cw_reg & ack_mask));

	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
			init_reg <= 1'b1;
		else if (swrst_reg)
			init_reg <= 1'b1;
		else if (straps_taken_reg)
			init_reg <= 1'b0;
	end

	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			state_reg <= ST_IDLE;
			last_cw_reg <= '0;
			match_cnt_reg <= 2'h0;
			partner_reg <= '0;
			flp_word_reg <= '0;
			res_reg <= '0;
		end
		else if (swrst_reg || !aneg_on)
		begin
			state_reg <= ST_IDLE;
			match_cnt_reg <= 2'h0;
			res_reg <= '0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					// Advertisement is latched only when a burst starts or the ack word is built, so writes wait for a restart
					// Wait for strap capture, though !res_reg.link_up already leaves on the first clock, so the first burst carries the reset advertisement of zero
					if ((init_reg && straps_taken_reg) || LINK_LOSS_IN || restart_pulse || !res_reg.link_up)
					begin
						state_reg <= ST_SEND;
						flp_word_reg <= adv_reg;
						match_cnt_reg <= 2'h0;
						res_reg <= '0;
					end
				end
				ST_SEND, ST_ACK:
				begin
					if (LINK_LOSS_IN || restart_pulse)
					begin
						state_reg <= ST_SEND;
						flp_word_reg <= adv_reg;
						match_cnt_reg <= 2'h0;
					end
					else if (NLP_DETECT_IN || IDLE100_DETECT_IN)
					begin
						state_reg <= ST_PAR;
						res_reg <= '{speed_100: IDLE100_DETECT_IN, full_duplex: 1'b0, link_up: 1'b1};
					end
					else if (CW_VALID_IN)
					begin
						last_cw_reg <= CW_IN;
						if (!cw_same || match_cnt_reg == 2'h0)
							match_cnt_reg <= 2'h1;
						else if (match_cnt_reg == 2'(CW_MATCH - 1))
						begin
							match_cnt_reg <= 2'h0;
							if (state_reg == ST_SEND)
							begin
								partner_reg <= CW_IN;
								state_reg <= ST_ACK;
								flp_word_reg <= adv_reg | (CW_WIDTH'(1) << ADV_ACK_BIT);
							end
							else
							begin
								state_reg <= ST_DONE;
								res_reg <= pick_mode(flp_word_reg[ADV_TECH_MSB:ADV_TECH_LSB]
									& partner_reg[ADV_TECH_MSB:ADV_TECH_LSB]);
							end
						end
						else
							match_cnt_reg <= match_cnt_reg + 2'h1;
					end
				end
				ST_DONE, ST_PAR:
				begin
					// Restart goes straight to sending, the one-cycle request is not seen again
					if (LINK_LOSS_IN || restart_pulse)
					begin
						state_reg <= ST_SEND;
						flp_word_reg <= adv_reg;
						match_cnt_reg <= 2'h0;
						res_reg <= '0;
					end
				end
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Mode selection
	// ------------------------------------------------------------
	plc_result_t mode;
	always_comb
	begin
		mode = res_reg;
		if (!aneg_on)
		begin
			if (!strap_aneg_reg && strap_tech_reg[1:0] != 2'h0)
			begin
				mode.speed_100 = strap_tech_reg[1];
				mode.full_duplex = strap_tech_reg[2];
			end
			else
			begin
				mode.speed_100 = ctl_reg[CTL_SPEED_BIT];
				mode.full_duplex = ctl_reg[CTL_DUPLEX_BIT];
			end
			mode.link_up = 1'b1;
		end
		// Control speed and duplex are ignored while negotiating
		if (aneg_on)
			mode = res_reg;
	end

	// ------------------------------------------------------------
	// Far-end fault pattern
	// ------------------------------------------------------------
	logic [5:0] fef_bit_cnt_reg;
	logic [1:0] fef_rep_cnt_reg;
	logic fef_run_reg;
	logic fef_cause;
	assign fef_cause = fef_en_reg && (!PARTNER_ACTIVE_IN || LOCK_ERROR_IN || x21_reg[X21_TXFAULT_BIT]);

	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			fef_run_reg <= 1'b0;
			fef_bit_cnt_reg <= 6'h00;
			fef_rep_cnt_reg <= 2'h0;
		end
		else if (!fef_run_reg)
		begin
			fef_bit_cnt_reg <= 6'h00;
			fef_rep_cnt_reg <= 2'h0;
			fef_run_reg <= fef_cause;
		end
		else if (fef_bit_cnt_reg == 6'(FEF_ONES))
		begin
			fef_bit_cnt_reg <= 6'h00;
			if (fef_rep_cnt_reg == 2'(FEF_REPEATS - 1))
			begin
				fef_rep_cnt_reg <= 2'h0;
				fef_run_reg <= fef_cause;
			end
			else
				fef_rep_cnt_reg <= fef_rep_cnt_reg + 2'h1;
		end
		else
			fef_bit_cnt_reg <= fef_bit_cnt_reg + 6'h01;
	end

	// ------------------------------------------------------------
	// Heartbeat and transmit tracking
	// ------------------------------------------------------------
	logic tx_prev_reg;
	logic [3:0] hb_cnt_reg;
	always_ff @(posedge MCLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			tx_prev_reg <= 1'b0;
			hb_cnt_reg <= 4'h0;
		end
		else
		begin
			tx_prev_reg <= TX_EN_IN;
			if (tx_prev_reg && !TX_EN_IN && x16_reg[X16_HEARTBEAT_BIT])
				hb_cnt_reg <= 4'(HB_CYCLES);
			else if (hb_cnt_reg != 4'h0)
				hb_cnt_reg <= hb_cnt_reg - 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic loop_local;
	logic loop_remote;
	assign loop_local = ctl_reg[CTL_LOOPBACK_BIT];
	assign loop_remote = x21_reg[X21_RLOOP_BIT] && mode.speed_100 && !FIBER_MODE_IN;

	assign CTL_OUT = ctl_reg;
	assign ADV_OUT = adv_reg;
	assign PARTNER_OUT = partner_reg;
	assign X21_OUT = x21_reg;
	assign X16_OUT = x16_reg;
	assign FLP_SEND_OUT = state_reg == ST_SEND || state_reg == ST_ACK;
	assign FLP_WORD_OUT = flp_word_reg;
	assign SPEED_100_OUT = mode.speed_100;
	assign FULL_DUPLEX_OUT = mode.full_duplex;
	assign LINK_UP_OUT = mode.link_up && (aneg_on ? (state_reg == ST_DONE || state_reg == ST_PAR) : 1'b1);
	assign FEF_ACTIVE_OUT = fef_run_reg;
	assign FEF_BIT_OUT = fef_run_reg && (fef_bit_cnt_reg != 6'(FEF_ONES));
	assign COL_OUT = hb_cnt_reg != 4'h0;
	assign LOCAL_LOOP_OUT = loop_local;
	assign REMOTE_LOOP_OUT = loop_remote;
	assign SIGNAL_DETECT_OUT = loop_local ? 1'b1 : (loop_remote ? 1'b0 : PARTNER_ACTIVE_IN);
	assign TX_DRIVER_EN_OUT = !loop_local;
	// Loopback forced 10M link falls while transmitting
	assign FORCE_LINK10_OUT = (loop_local || loop_remote || x21_reg[X21_FORCE10_BIT]) && !TX_EN_IN;
	assign SOFT_RESET_OUT = swrst_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_tx_end;
		tx_prev_reg && !TX_EN_IN && x16_reg[X16_HEARTBEAT_BIT];
	endsequence
	chk_heartbeat_pulse: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		s_tx_end |=> COL_OUT[*5]) else $error("heartbeat pulse too short");
	chk_fef_zero_slot: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(fef_run_reg && fef_bit_cnt_reg == 6'(FEF_ONES)) |-> !FEF_BIT_OUT) else $error("fault zero missing");
	chk_local_loop_sd: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		loop_local |-> SIGNAL_DETECT_OUT && !TX_DRIVER_EN_OUT) else $error("local loop pins wrong");
	chk_remote_loop_sd: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(loop_remote && !loop_local) |-> !SIGNAL_DETECT_OUT) else $error("remote loop detect high");
	chk_link10_drop: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		TX_EN_IN |-> !FORCE_LINK10_OUT) else $error("forced link kept while sending");
	chk_swrst_clears: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		$rose(swrst_reg) |-> ##[1:40] !swrst_reg) else $error("soft reset stuck");
	chk_adv_no_set: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(adv_reg[ADV_TECH_MSB:ADV_TECH_LSB] & ~adv_cap_reg) == 4'h0) else $error("strap-cleared bit set");
	chk_adv_no_restart: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(ADV_WR_IN && state_reg == ST_DONE && !LINK_LOSS_IN && !restart_pulse && !swrst_reg && aneg_on)
		|=> state_reg == ST_DONE) else $error("write restarted negotiation");
	chk_parallel_half: assert property (@(posedge MCLK_IN) disable iff (!RST_B_IN)
		(state_reg == ST_PAR && aneg_on) |-> !FULL_DUPLEX_OUT) else $error("parallel detect not half");
endmodule : plc_link_ctrl

// File: rtl/plc_pkg.sv
// Package of constants and carrier types for the link negotiation control block
package plc_pkg;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL_RESET_BIT = 15;
	localparam int CTL_LOOPBACK_BIT = 14;
	localparam int CTL_SPEED_BIT = 13;
	localparam int CTL_ANEG_BIT = 12;
	localparam int CTL_RESTART_BIT = 9;
	localparam int CTL_DUPLEX_BIT = 8;
	localparam int X21_FORCE10_BIT = 14;
	localparam int X21_TXFAULT_BIT = 7;
	localparam int X21_RLOOP_BIT = 3;
	localparam int X16_HEARTBEAT_BIT = 11;
	localparam int ADV_TECH_LSB = 5;
	localparam int ADV_TECH_MSB = 8;
	localparam int ADV_ACK_BIT = 14;
	localparam int ABIL_10HD = 5;
	localparam int ABIL_10FD = 6;
	localparam int ABIL_100HD = 7;
	localparam int ABIL_100FD = 8;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int BIT_TIME_NS = 100;
	localparam int HB_MIN_BITS = 5;
	localparam int HB_MAX_BITS = 15;
	localparam int HB_CYCLES_RAW = (HB_MIN_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HB_CYCLES = (HB_CYCLES_RAW < 1) ? 1 : HB_CYCLES_RAW;
	localparam int SWRST_CYCLES = 16;
	localparam int FEF_ONES = 63;
	localparam int FEF_REPEATS = 3;
	localparam int CW_MATCH = 3;
	localparam logic [15:0] CTL_RESET_VAL = 16'h3100;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		PLC_MODE_10HD = 4'h1,
		PLC_MODE_10FD = 4'h2,
		PLC_MODE_100HD = 4'h4,
		PLC_MODE_100FD = 4'h8
	} plc_mode_t;
	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_SEND = 5'h02,
		ST_ACK = 5'h04,
		ST_DONE = 5'h08,
		ST_PAR = 5'h10
	} plc_state_t;
	typedef struct packed
	{
		logic speed_100;
		logic full_duplex;
		logic link_up;
	} plc_result_t;
endpackage : plc_pkg

// File: dv/plc_partner_model.sv
// Link partner model that sends bursts of identical code words
`timescale 1ns/1ps
module plc_partner_model
	import plc_pkg::*;
#(
	parameter int GAP = 4
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire logic [15:0] word_in,
	output logic cw_valid_out,
	output logic [15:0] cw_out,
	output logic busy_out
);
	logic [2:0] left_reg;
	logic [7:0] gap_reg;
	logic [15:0] word_reg;
	// ------------------------------------------------------------
	// Burst sender
	// ------------------------------------------------------------
	// Between words the data lines toggle so a stale word never looks valid
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			left_reg <= 3'h0;
			gap_reg <= 8'h00;
			word_reg <= 16'h0000;
			cw_valid_out <= 1'b0;
			cw_out <= 16'h0000;
		end
		else if (start_in)
		begin
			left_reg <= 3'(CW_MATCH);
			word_reg <= word_in;
			gap_reg <= 8'h00;
			cw_valid_out <= 1'b0;
		end
		else if (left_reg != 3'h0 && gap_reg == 8'h00)
		begin
			cw_valid_out <= 1'b1;
			cw_out <= word_reg;
			left_reg <= left_reg - 3'h1;
			gap_reg <= 8'(GAP);
		end
		else
		begin
			cw_valid_out <= 1'b0;
			cw_out <= ~cw_out;
			if (gap_reg != 8'h00)
				gap_reg <= gap_reg - 8'h01;
		end
	end
	assign busy_out = (left_reg != 3'h0) || cw_valid_out;
endmodule : plc_partner_model

// File: dv/plc_link_ctrl_tb_top.sv
// Self-checking testbench for the link negotiation control block
`timescale 1ns/1ps
module plc_link_ctrl_tb_top;
	import plc_pkg::*;
	logic mclk, rst_b, strap_an, fiber, ctl_wr, adv_wr, x21_wr, x16_wr, fef_wr, fef_en, nlp, idle100;
	logic partner_act, lock_err, tx_en, p_start, p_busy, cw_valid, f10_tx;
	logic flp_send, spd, fdx, link_up, fef_act, fef_bit, col, lloop, rloop, sdet, txdrv, f10, srst;
	logic [2:0] tech;
	logic [15:0] wdata, p_word, cw, ctl_q, adv_q, part_q, x21_q, x16_q, flp_word;
	int error_cnt, num_checks, cycles, hb, ones;
	logic [15:0] abil [4] = '{16'h01E1, 16'h0061, 16'h0021, 16'h00A1};
	logic [2:0] res [4] = '{3'h7, 3'h3, 3'h1, 3'h5};
	logic [2:0] ts [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};
	logic [1:0] fm [6] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h3, 2'h3};
	plc_link_ctrl u_plc_link_ctrl (.MCLK_IN(mclk), .RST_B_IN(rst_b), .STRAP_AUTONEG_ENABLE_IN(strap_an),
		.TECH_SELECT_STRAPS_IN(tech), .FIBER_MODE_IN(fiber), .CTL_WR_IN(ctl_wr), .CTL_WDATA_IN(wdata),
		.ADV_WR_IN(adv_wr), .ADV_WDATA_IN(wdata), .X21_WR_IN(x21_wr), .X21_WDATA_IN(wdata),
		.X16_WR_IN(x16_wr), .X16_WDATA_IN(wdata), .FEF_ENABLE_WR_IN(fef_wr), .FEF_ENABLE_IN(fef_en),
		.CW_VALID_IN(cw_valid), .CW_IN(cw), .NLP_DETECT_IN(nlp), .IDLE100_DETECT_IN(idle100),
		.LINK_LOSS_IN(1'b0), .PARTNER_ACTIVE_IN(partner_act), .LOCK_ERROR_IN(lock_err), .TX_EN_IN(tx_en),
		.CTL_OUT(ctl_q), .ADV_OUT(adv_q), .PARTNER_OUT(part_q), .X21_OUT(x21_q), .X16_OUT(x16_q),
		.FLP_SEND_OUT(flp_send), .FLP_WORD_OUT(flp_word), .SPEED_100_OUT(spd), .FULL_DUPLEX_OUT(fdx),
		.LINK_UP_OUT(link_up), .FEF_ACTIVE_OUT(fef_act), .FEF_BIT_OUT(fef_bit), .COL_OUT(col),
		.LOCAL_LOOP_OUT(lloop), .REMOTE_LOOP_OUT(rloop), .SIGNAL_DETECT_OUT(sdet),
		.TX_DRIVER_EN_OUT(txdrv), .FORCE_LINK10_OUT(f10), .SOFT_RESET_OUT(srst));
	plc_partner_model u_plc_partner_model (.clk_in(mclk), .rst_b_in(rst_b), .start_in(p_start),
		.word_in(p_word), .cw_valid_out(cw_valid), .cw_out(cw), .busy_out(p_busy));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude();
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
			begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic waitv(ref logic s, input logic v, input int n);
		for (int i = 0; i < n && s !== v; i++)
		begin
			@(posedge mclk);
			#1;
		end
	endtask : waitv
	task automatic do_reset(input logic an, input logic [2:0] t, input logic fb);
		@(posedge mclk);
		rst_b <= 1'b0;
		strap_an <= an;
		tech <= t;
		fiber <= fb;
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
	endtask : do_reset
	// Selects 0 control, 1 advertisement, 2 reg21, 3 reg16, 4 fault enable
	task automatic wr(input int sel, input logic [15:0] d);
		@(posedge mclk);
		wdata <= d;
		ctl_wr <= (sel == 0);
		adv_wr <= (sel == 1);
		x21_wr <= (sel == 2);
		x16_wr <= (sel == 3);
		fef_wr <= (sel == 4);
		if (sel == 4)
			fef_en <= d[0];
		@(posedge mclk);
		{ctl_wr, adv_wr, x21_wr, x16_wr, fef_wr} <= 5'h00;
		#1;
	endtask : wr
	task automatic send(input logic [15:0] w);
		@(posedge mclk);
		p_start <= 1'b1;
		p_word <= w;
		@(posedge mclk);
		p_start <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		waitv(p_busy, 1'b0, 40);
		repeat (3) @(posedge mclk);
		#1;
	endtask : send
	// Sends one packet, then counts collision pulse cycles after it
	task automatic pkt();
		hb = 0;
		@(posedge mclk);
		tx_en <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		f10_tx = f10;
		@(posedge mclk);
		tx_en <= 1'b0;
		repeat (20)
		begin
			@(posedge mclk);
			#1;
			if (col === 1'b1)
				hb++;
		end
	endtask : pkt
	// ------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			error_cnt++;
			conclude();
		end
	end
	initial
	begin
		{rst_b, ctl_wr, adv_wr, x21_wr, x16_wr, fef_wr, fef_en, p_start, nlp, idle100, lock_err, tx_en, fiber} = '0;
		strap_an = 1'b1;
		tech = 3'h7;
		partner_act = 1'b1;
		wdata = 16'h0000;
		p_word = 16'h0000;
		do_reset(1'b1, 3'h7, 1'b0);
		chk("aneg bit", 16'h0001, {15'h0000, ctl_q[CTL_ANEG_BIT]});
		chk("adv straps", 16'h000F, {12'h000, adv_q[8:5]});
		chk("flp send", 16'h0001, {15'h0000, flp_send});
		wr(1, 16'h0001);
		chk("adv cleared", 16'h0000, {12'h000, adv_q[8:5]});
		chk("no restart", 16'h0001, {15'h0000, flp_send});
		wr(1, 16'h01E1);
		chk("adv set again", 16'h000F, {12'h000, adv_q[8:5]});
		for (int k = 0; k < 4; k++)
		begin
			if (k > 0)
				wr(0, 16'h1200);
			send(abil[k]);
			chk("partner word", abil[k], part_q);
			chk("ack sent", 16'h0001, {15'h0000, flp_word[ADV_ACK_BIT]});
			send(abil[k] | 16'h4000);
			waitv(link_up, 1'b1, 100);
			chk("resolved mode", {13'h0000, res[k]}, {13'h0000, spd, fdx, link_up});
		end
		wr(1, 16'h0021);
		chk("adv write no restart", 16'h0001, {14'h0000, flp_send, link_up});
		wr(0, 16'h1000);
		chk("speed kept", 16'h0005, {13'h0000, spd, fdx, link_up});
		wr(0, 16'h5000);
		chk("local loop", 16'h000D, {12'h000, lloop, sdet, txdrv, f10});
		pkt();
		chk("link10 in tx", 16'h0000, {15'h0000, f10_tx});
		chk("link10 back", 16'h0001, {15'h0000, f10});
		chk("no heartbeat", 16'h0000, 16'(hb));
		wr(0, 16'h1000);
		wr(2, 16'h0008);
		chk("remote loop", 16'h0002, {14'h0000, rloop, sdet});
		wr(2, 16'h0000);
		wr(3, 16'h0800);
		pkt();
		chk("heartbeat", 16'(HB_CYCLES), 16'(hb));
		wr(2, 16'h0080);
		repeat (4) @(posedge mclk);
		#1;
		chk("fault default off", 16'h0000, {15'h0000, fef_act});
		wr(4, 16'h0001);
		for (int c = 0; c < 3; c++)
		begin
			@(posedge mclk);
			lock_err <= (c == 1);
			partner_act <= (c != 2);
			waitv(fef_act, 1'b1, 20);
			chk("fault on", 16'h0001, {15'h0000, fef_act});
			if (c == 0)
			begin
				waitv(fef_bit, 1'b0, 300);
				waitv(fef_bit, 1'b1, 5);
				ones = 0;
				while (fef_bit === 1'b1 && ones < 100)
				begin
					ones++;
					@(posedge mclk);
					#1;
				end
				chk("fault ones", 16'h003F, 16'(ones));
				wr(2, 16'h0000);
			end
			@(posedge mclk);
			lock_err <= 1'b0;
			partner_act <= 1'b1;
			waitv(fef_act, 1'b0, 400);
			chk("fault off", 16'h0000, {15'h0000, fef_act});
		end
		wr(0, 16'h9000);
		chk("soft reset", 16'h0001, {15'h0000, srst});
		wr(3, 16'h0800);
		waitv(srst, 1'b0, 40);
		chk("reset done", 16'h0000, {14'h0000, ctl_q[CTL_RESET_BIT], link_up});
		chk("write refused", 16'h0000, x16_q);
		do_reset(1'b1, 3'h1, 1'b0);
		wr(1, 16'h01E1);
		chk("adv no set", 16'h0001, {12'h000, adv_q[8:5]});
		for (int p = 0; p < 2; p++)
		begin
			do_reset(1'b1, 3'h7, 1'b0);
			@(posedge mclk);
			nlp <= (p == 0);
			idle100 <= (p == 1);
			waitv(link_up, 1'b1, 200);
			chk("parallel detect", {13'h0000, p[0], 2'h1}, {13'h0000, spd, fdx, link_up});
			nlp <= 1'b0;
			idle100 <= 1'b0;
		end
		for (int s = 0; s < 6; s++)
		begin
			do_reset(1'b0, ts[s], 1'b0);
			chk("forced mode", {13'h0000, 1'b0, fm[s]}, {13'h0000, ctl_q[CTL_ANEG_BIT], spd, fdx});
		end
		do_reset(1'b0, 3'h4, 1'b0);
		wr(0, 16'h2100);
		chk("managed mode", 16'h0003, {14'h0000, spd, fdx});
		wr(0, 16'h0000);
		chk("managed mode", 16'h0000, {14'h0000, spd, fdx});
		@(posedge mclk);
		lock_err <= 1'b1;
		do_reset(1'b1, 3'h7, 1'b1);
		waitv(fef_act, 1'b1, 20);
		chk("fiber fault default", 16'h0001, {15'h0000, fef_act});
		conclude();
	end
endmodule : plc_link_ctrl_tb_top
